// ===== core/aic_map.vh
`ifndef AIC_MAP_VH
`define AIC_MAP_VH
`define AIC_REG_DATA 3'h0
`define AIC_REG_FEATURE 3'h1
`define AIC_REG_SECT_CNT 3'h2
`define AIC_REG_SECT_NUM 3'h3
`define AIC_REG_CYL_LO 3'h4
`define AIC_REG_CYL_HI 3'h5
`define AIC_REG_DRV_HEAD 3'h6
`define AIC_REG_CMD 3'h7
`define AIC_CMD_IDENTIFY 8'hec
`define AIC_CMD_IDLE_A 8'h97
`define AIC_CMD_IDLE_B 8'he3
`define AIC_CMD_IDLE_IMM_A 8'h95
`define AIC_CMD_IDLE_IMM_B 8'he1
`define AIC_CMD_INIT_PARAM 8'h91
`define AIC_ST_BSY 7
`define AIC_ST_RDY 6
`define AIC_ST_DRQ 3
`define AIC_ST_ERR 0
`define AIC_DH_DRIVE 4
`define AIC_W47 16'h0001
`define AIC_W49 16'h0200
`define AIC_W51 16'h0200
`define AIC_W53 16'h0003
`define AIC_W59 16'h0100
`define AIC_W63 16'h0407
`define AIC_W64 16'h0003
`define AIC_CYCLE_80 16'h0050
`define AIC_W163 16'h0492
`define AIC_W164_HI 10'h000
`define AIC_IO_MODE 3'h3
`define AIC_MEM_MODE 3'h3
`define AIC_W22 16'h0004
`define AIC_SPACE 8'h20
`define AIC_TICK_NS 5000000
`define AIC_CLK_NS 10
`define AIC_WORDS 256
`endif

// ===== core/aic_word_mem.v
`timescale 1ns/100ps
`default_nettype none
// =====================================
// small ascii string store, registered read
module aic_word_mem #(
   parameter AW = 5
) (
   // clock
   input wire clk,
   // write port
   input wire wr_en,
   input wire [AW-1:0] wr_addr,
   input wire [15:0] wr_data,
   // read port
   input wire [AW-1:0] rd_addr,
   output reg [15:0] rd_data_ff
);
   reg [15:0] mem_ff [0:(1<<AW)-1];
   always @(posedge clk) begin
      if (wr_en) begin
         mem_ff[wr_addr] <= wr_data;
      end
      rd_data_ff <= mem_ff[rd_addr];
   end
endmodule // aic_word_mem
`default_nettype wire

// ===== core/aic_tick_timer.v
`timescale 1ns/100ps
`default_nettype none
`include "aic_map.vh"
// =====================================
// auto power-down timer, count in 5 ms units
module aic_tick_timer #(
   parameter TICK_CYC = `AIC_TICK_NS / `AIC_CLK_NS
) (
   // clock and reset
   input wire clk,
   input wire rst_b,
   // control
   input wire load,
   input wire [7:0] count,
   input wire wake,
   // status
   output reg expired_ff
);
   reg [31:0] pre_ff;
   reg [7:0] cnt_ff;
   reg run_ff;
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pre_ff <= 32'h0000_0000;
         cnt_ff <= 8'h00;
         run_ff <= 1'b0;
         expired_ff <= 1'b0;
      end else if (load) begin
         pre_ff <= 32'h0000_0000;
         cnt_ff <= count;
         run_ff <= (count != 8'h00);
         expired_ff <= 1'b0;
      end else if (wake) begin
         pre_ff <= 32'h0000_0000;
         expired_ff <= 1'b0;
      end else if (run_ff && !expired_ff) begin
         if (pre_ff == TICK_CYC - 1) begin
            pre_ff <= 32'h0000_0000;
            if (cnt_ff == 8'h01) begin
               expired_ff <= 1'b1;
               cnt_ff <= count;
            end else begin
               cnt_ff <= cnt_ff - 8'h01;
            end
         end else begin
            pre_ff <= pre_ff + 32'h0000_0001;
         end
      end
   end
endmodule // aic_tick_timer
`default_nettype wire

// ===== core/aic_cmd_unit.v
`timescale 1ns/100ps
`default_nettype none
`include "aic_map.vh"
// =====================================
// task-file command unit: identify, idle, idle immediate, init params
module aic_cmd_unit #(
   parameter [15:0] CFG_DEFAULT = 16'h0000, // arbitrary value
   parameter [15:0] CFG_ALT = 16'h0001, // arbitrary value
   parameter [15:0] DEF_CYLS = 16'h0100,
   parameter [15:0] DEF_HEADS = 16'h0004,
   parameter [15:0] DEF_SPT = 16'h0020,
   parameter [31:0] CARD_SECTORS = 32'h0002_0000,
   parameter TICK_CYC = `AIC_TICK_NS / `AIC_CLK_NS
) (
   // clock and reset
   input wire clk,
   input wire rst_b,
   // mode strap and drive number
   input wire direct_disk_mode,
   input wire drive_number,
   // task-file access
   input wire [2:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [15:0] reg_wdata,
   output reg [15:0] reg_rdata_ff,
   // string load port
   input wire str_wr,
   input wire [4:0] str_addr,
   input wire [15:0] str_data,
   // status
   output reg [7:0] status_ff,
   output reg intrq_ff,
   output reg idle_mode_ff,
   output reg auto_pd_en_ff,
   output reg power_down_ff,
   output reg [7:0] sectors_per_track_ff,
   output reg [3:0] max_head_ff
);
   // =====================================
   // states
   localparam [4:0] ST_IDLE = 5'b00001;
   localparam [4:0] ST_EXEC = 5'b00010;
   localparam [4:0] ST_FETCH = 5'b00100;
   localparam [4:0] ST_XFER = 5'b01000;
   localparam [4:0] ST_DONE = 5'b10000;

   reg [4:0] state_ff;
   reg [7:0] feature_ff, sect_cnt_ff, sect_num_ff, cyl_lo_ff, cyl_hi_ff, drv_head_ff, cmd_ff;
   reg [7:0] word_ff, fetch_word;
   reg [15:0] data_ff;
   reg card_mode_s1_ff, card_mode_s2_ff, drv_s1_ff, drv_s2_ff;
   reg tmr_load_ff, tmr_wake_ff;
   reg [15:0] nxt_data;
   reg [4:0] mem_addr;
   wire [15:0] mem_q;
   wire tmr_expired;
   wire selected;
   wire [31:0] cur_cap;

   assign selected = (drv_head_ff[`AIC_DH_DRIVE] == drv_s2_ff);
   assign cur_cap = {16'h0000, DEF_CYLS} * {16'h0000, sectors_per_track_ff, 8'h00} / 32'h0000_0100
                    * {28'h000_0000, max_head_ff} + {16'h0000, DEF_CYLS} * {24'h00_0000, sectors_per_track_ff};

   // =====================================
   // helpers
   function is_idle_cmd;
      input [7:0] c;
      is_idle_cmd = (c == `AIC_CMD_IDLE_A) || (c == `AIC_CMD_IDLE_B);
   endfunction

   function is_idle_imm_cmd;
      input [7:0] c;
      is_idle_imm_cmd = (c == `AIC_CMD_IDLE_IMM_A) || (c == `AIC_CMD_IDLE_IMM_B);
   endfunction

   // =====================================
   // pin synchronisers
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         card_mode_s1_ff <= 1'b0;
         card_mode_s2_ff <= 1'b0;
         drv_s1_ff <= 1'b0;
         drv_s2_ff <= 1'b0;
      end else begin
         card_mode_s1_ff <= direct_disk_mode;
         card_mode_s2_ff <= card_mode_s1_ff;
         drv_s1_ff <= drive_number;
         drv_s2_ff <= drv_s1_ff;
      end
   end

   // =====================================
   // strings: serial 0-9, firmware 10-13, model 14-31 wraps into 5-bit space
   // model words beyond the store read as spaces; keeps the store at 32 words
   // the store is addressed with the word about to be fetched, so its registered output is ready in fetch
   always @* begin
      fetch_word = word_ff + {7'h00, state_ff == ST_XFER && reg_rd && reg_addr == `AIC_REG_DATA};
      mem_addr = 5'h00;
      if (fetch_word >= 8'd10 && fetch_word <= 8'd19) begin
         mem_addr = fetch_word[4:0] - 5'd10;
      end else if (fetch_word >= 8'd23 && fetch_word <= 8'd44) begin
         mem_addr = fetch_word[4:0] - 5'd13;
      end
   end

   aic_word_mem #(
      .AW(5)
   ) u_mem (
      .clk(clk),
      .wr_en(str_wr),
      .wr_addr(str_addr),
      .wr_data(str_data),
      .rd_addr(mem_addr),
      .rd_data_ff(mem_q)
   );

   aic_tick_timer #(
      .TICK_CYC(TICK_CYC)
   ) u_tmr (
      .clk(clk),
      .rst_b(rst_b),
      .load(tmr_load_ff),
      .count(sect_cnt_ff),
      .wake(tmr_wake_ff),
      .expired_ff(tmr_expired)
   );

   // =====================================
   // identify word table
   always @* begin
      nxt_data = 16'h0000;
      case (word_ff)
         8'd0: nxt_data = card_mode_s2_ff ? CFG_ALT : CFG_DEFAULT;
         8'd1: nxt_data = DEF_CYLS;
         8'd3: nxt_data = DEF_HEADS;
         8'd6: nxt_data = DEF_SPT;
         8'd7: nxt_data = CARD_SECTORS[31:16];
         8'd8: nxt_data = CARD_SECTORS[15:0];
         8'd22: nxt_data = `AIC_W22;
         8'd45, 8'd46: nxt_data = {`AIC_SPACE, `AIC_SPACE};
         8'd47: nxt_data = `AIC_W47;
         8'd49: nxt_data = `AIC_W49;
         8'd51: nxt_data = `AIC_W51;
         8'd53: nxt_data = `AIC_W53;
         8'd54: nxt_data = DEF_CYLS;
         8'd55: nxt_data = {12'h000, max_head_ff} + 16'h0001;
         8'd56: nxt_data = {8'h00, sectors_per_track_ff};
         8'd57: nxt_data = cur_cap[15:0];
         8'd58: nxt_data = cur_cap[31:16];
         8'd59: nxt_data = `AIC_W59;
         8'd60: nxt_data = CARD_SECTORS[15:0];
         8'd61: nxt_data = CARD_SECTORS[31:16];
         8'd63: nxt_data = card_mode_s2_ff ? `AIC_W63 : 16'h0000;
         8'd64: nxt_data = `AIC_W64;
         8'd65, 8'd66: nxt_data = card_mode_s2_ff ? `AIC_CYCLE_80 : 16'h0000;
         8'd67, 8'd68: nxt_data = `AIC_CYCLE_80;
         8'd163: nxt_data = `AIC_W163;
         8'd164: nxt_data = {`AIC_W164_HI, `AIC_MEM_MODE, `AIC_IO_MODE};
         default: begin
            if ((word_ff >= 8'd10 && word_ff <= 8'd19) || (word_ff >= 8'd23 && word_ff <= 8'd44)) begin
               nxt_data = mem_q;
            end
         end
      endcase
   end

   // =====================================
   // task file and command sequencer
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= ST_IDLE;
         feature_ff <= 8'h00;
         sect_cnt_ff <= 8'h01;
         sect_num_ff <= 8'h01;
         cyl_lo_ff <= 8'h00;
         cyl_hi_ff <= 8'h00;
         drv_head_ff <= 8'h00;
         cmd_ff <= 8'h00;
         word_ff <= 8'h00;
         data_ff <= 16'h0000;
         status_ff <= 8'h40;
         intrq_ff <= 1'b0;
         idle_mode_ff <= 1'b0;
         auto_pd_en_ff <= 1'b0;
         power_down_ff <= 1'b0;
         sectors_per_track_ff <= 8'h20;
         max_head_ff <= 4'h3;
         reg_rdata_ff <= 16'h0000;
         tmr_load_ff <= 1'b0;
         tmr_wake_ff <= 1'b0;
      end else begin
         tmr_load_ff <= 1'b0;
         tmr_wake_ff <= 1'b0;
         // only in idle state: a stale expiry must not come back in the cycle a command wakes the timer
         power_down_ff <= auto_pd_en_ff && (power_down_ff || tmr_expired) && state_ff == ST_IDLE;
         // register reads; status read clears the interrupt
         if (reg_rd) begin
            if (reg_addr == `AIC_REG_DATA) begin
               reg_rdata_ff <= data_ff;
            end else if (reg_addr == `AIC_REG_FEATURE) begin
               reg_rdata_ff <= {8'h00, feature_ff};
            end else if (reg_addr == `AIC_REG_SECT_CNT) begin
               reg_rdata_ff <= {8'h00, sect_cnt_ff};
            end else if (reg_addr == `AIC_REG_SECT_NUM) begin
               reg_rdata_ff <= {8'h00, sect_num_ff};
            end else if (reg_addr == `AIC_REG_CYL_LO) begin
               reg_rdata_ff <= {8'h00, cyl_lo_ff};
            end else if (reg_addr == `AIC_REG_CYL_HI) begin
               reg_rdata_ff <= {8'h00, cyl_hi_ff};
            end else if (reg_addr == `AIC_REG_DRV_HEAD) begin
               reg_rdata_ff <= {8'h00, drv_head_ff};
            end else begin
               reg_rdata_ff <= {8'h00, status_ff};
               intrq_ff <= 1'b0;
            end
         end
         // task-file writes are refused while busy
         if (reg_wr && !status_ff[`AIC_ST_BSY]) begin
            if (reg_addr == `AIC_REG_FEATURE) begin
               feature_ff <= reg_wdata[7:0];
            end else if (reg_addr == `AIC_REG_SECT_CNT) begin
               sect_cnt_ff <= reg_wdata[7:0];
            end else if (reg_addr == `AIC_REG_SECT_NUM) begin
               sect_num_ff <= reg_wdata[7:0];
            end else if (reg_addr == `AIC_REG_CYL_LO) begin
               cyl_lo_ff <= reg_wdata[7:0];
            end else if (reg_addr == `AIC_REG_CYL_HI) begin
               cyl_hi_ff <= reg_wdata[7:0];
            end else if (reg_addr == `AIC_REG_DRV_HEAD) begin
               drv_head_ff <= reg_wdata[7:0];
            end else if (reg_addr == `AIC_REG_CMD && state_ff == ST_IDLE) begin
               cmd_ff <= reg_wdata[7:0];
               status_ff <= 8'h80;
               intrq_ff <= 1'b0;
               tmr_wake_ff <= 1'b1;
               power_down_ff <= 1'b0;
               state_ff <= ST_EXEC;
            end
         end
         case (state_ff)
            ST_IDLE: begin
            end
            ST_EXEC: begin
               if (!selected) begin
                  status_ff <= 8'h40;
                  state_ff <= ST_IDLE;
               end else if (cmd_ff == `AIC_CMD_IDENTIFY) begin
                  word_ff <= 8'h00;
                  state_ff <= ST_FETCH;
               end else if (is_idle_cmd(cmd_ff)) begin
                  idle_mode_ff <= 1'b1;
                  auto_pd_en_ff <= (sect_cnt_ff != 8'h00);
                  tmr_load_ff <= 1'b1;
                  state_ff <= ST_DONE;
               end else if (is_idle_imm_cmd(cmd_ff)) begin
                  idle_mode_ff <= 1'b1;
                  state_ff <= ST_DONE;
               end else if (cmd_ff == `AIC_CMD_INIT_PARAM) begin
                  sectors_per_track_ff <= sect_cnt_ff;
                  max_head_ff <= drv_head_ff[3:0];
                  state_ff <= ST_DONE;
               end else begin
                  status_ff <= 8'h41; // unsupported command aborts
                  intrq_ff <= 1'b1;
                  state_ff <= ST_IDLE;
               end
            end
            ST_FETCH: begin
               // busy for one cycle between words; the store already answered at the read edge
               data_ff <= nxt_data;
               if (word_ff == 8'h00) begin
                  status_ff <= 8'h48;
                  intrq_ff <= 1'b1;
               end else begin
                  status_ff <= 8'h48;
               end
               state_ff <= ST_XFER;
            end
            ST_XFER: begin
               if (reg_rd && reg_addr == `AIC_REG_DATA) begin
                  if (word_ff == 8'hff) begin
                     status_ff <= 8'h40;
                     state_ff <= ST_IDLE;
                  end else begin
                     word_ff <= word_ff + 8'h01;
                     status_ff <= 8'h80;
                     state_ff <= ST_FETCH;
                  end
               end
            end
            ST_DONE: begin
               status_ff <= 8'h40;
               intrq_ff <= 1'b1;
               state_ff <= ST_IDLE;
            end
            default: begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end
endmodule // aic_cmd_unit
`default_nettype wire

// ===== sim/aic_cmd_unit_chk.sv
`timescale 1ns/100ps
`default_nettype none
// =====================================
// task-file protocol checks
module aic_cmd_unit_chk (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // task file
   input wire logic drive_number,
   input wire logic [2:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata_ff,
   // status
   input wire logic [7:0] status_ff,
   input wire logic intrq_ff,
   input wire logic idle_mode_ff,
   input wire logic auto_pd_en_ff,
   input wire logic [7:0] sectors_per_track_ff,
   input wire logic [3:0] max_head_ff
);
   logic [7:0] dh_ff;
   logic [7:0] cnt_ff;
   logic [7:0] wcnt_ff;
   logic take;
   logic mine;
   logic rd_data;
   logic [7:0] op;
   assign op = reg_wdata[7:0];
   assign take = reg_wr && reg_addr == 3'h7 && !status_ff[7] && !status_ff[3];
   assign mine = dh_ff[4] == drive_number;
   assign rd_data = reg_rd && reg_addr == 3'h0 && status_ff[3];
   // shadow of parameter writes; writes while busy are dropped, so mirror that
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dh_ff <= 8'h00;
         cnt_ff <= 8'h00;
         wcnt_ff <= 8'h00;
      end else begin
         if (reg_wr && !status_ff[7] && reg_addr == 3'h6) dh_ff <= op;
         if (reg_wr && !status_ff[7] && reg_addr == 3'h2) cnt_ff <= op;
         if (take && op == 8'hec) wcnt_ff <= 8'h00;
         else if (rd_data) wcnt_ff <= wcnt_ff + 8'h01;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   chk_busy_short: assert property ($rose(status_ff[7]) |-> ##[1:2] !status_ff[7])
      else $error("busy held too long");
   chk_idle_seq: assert property (take && mine && op inside {8'h97, 8'he3}
      |=> status_ff[7] ##2 (!status_ff[7] && intrq_ff && idle_mode_ff))
      else $error("idle sequence wrong");
   chk_idle_timer: assert property (take && mine && op inside {8'h97, 8'he3}
      |-> ##3 auto_pd_en_ff == (cnt_ff != 8'h00))
      else $error("auto power down enable wrong");
   chk_idle_now: assert property (take && mine && op inside {8'h95, 8'he1}
      |=> status_ff[7] ##2 (!status_ff[7] && intrq_ff && idle_mode_ff))
      else $error("idle immediate sequence wrong");
   chk_imm_ignores: assert property (take && mine && op inside {8'h95, 8'he1}
      |-> ##3 auto_pd_en_ff == $past(auto_pd_en_ff, 3))
      else $error("idle immediate used parameters");
   chk_init_param: assert property (take && mine && op == 8'h91
      |-> ##3 sectors_per_track_ff == cnt_ff && max_head_ff == dh_ff[3:0])
      else $error("drive parameters not taken");
   chk_ident_ready: assert property (take && mine && op == 8'hec |-> ##3 status_ff == 8'h48 && intrq_ff)
      else $error("identify data not offered");
   chk_word_164: assert property (rd_data && wcnt_ff == 8'd164 |=> reg_rdata_ff[5:0] == 6'h1b)
      else $error("timing mode word wrong");
   chk_other_drv: assert property (take && !mine |-> ##2 status_ff == 8'h40 && !intrq_ff)
      else $error("other drive command answered");
   chk_drq_gap: assert property (rd_data |=> !status_ff[3])
      else $error("data request not dropped after read");
   chk_status_clr: assert property (reg_rd && reg_addr == 3'h7 && !status_ff[7] |=> !intrq_ff)
      else $error("status read left interrupt set");
endmodule // aic_cmd_unit_chk
bind aic_cmd_unit aic_cmd_unit_chk aic_cmd_unit_chk_i (.*);
`default_nettype wire

// ===== sim/aic_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// =====================================
// host side of the task file; strobes change on the falling edge
module aic_host_model (
   // clock
   input wire logic clk,
   // strobes toward the card
   output logic [2:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [15:0] reg_wdata,
   // read data from the card
   input wire logic [15:0] reg_rdata_ff
);
   initial begin
      reg_addr = 3'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 16'h0000;
   end
   // upper byte is ignored by the card, so it carries junk on purpose
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = {~d, d};
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_wdata = ~reg_wdata;
   endtask
   task automatic rd(input logic [2:0] a, output logic [15:0] q);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      q = reg_rdata_ff;
   endtask
endmodule // aic_host_model
`default_nettype wire

// ===== sim/aic_cmd_unit_test.sv
`timescale 1ns/100ps
`default_nettype none
// =====================================
// bench top
module aic_cmd_unit_test;
   localparam int TICK = 10;
   localparam logic [15:0] CFG_D = 16'h0a5a; // arbitrary value
   localparam logic [15:0] CFG_A = 16'h05a5; // arbitrary value
   localparam logic [31:0] SECTORS = 32'h0003_1234;
   localparam logic [31:0] CAP = 32'h0000_0900 * 32'h0000_0080;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic direct_disk_mode = 1'b0;
   logic drive_number = 1'b0;
   logic str_wr = 1'b0;
   logic [4:0] str_addr = 5'h00;
   logic [15:0] str_data = 16'h0000;
   wire [2:0] reg_addr;
   wire reg_wr;
   wire reg_rd;
   wire [15:0] reg_wdata;
   wire [15:0] reg_rdata_ff;
   wire [7:0] status_ff;
   wire intrq_ff, idle_mode_ff, auto_pd_en_ff, power_down_ff;
   wire [7:0] sectors_per_track_ff;
   wire [3:0] max_head_ff;
   int fail_count = 0;
   int tests_run = 0;
   int cycles = 0;
   integer seed = 32'hb0a8;
   logic [15:0] sw [0:31];
   logic [15:0] v;
   logic [7:0] n;
   logic [7:0] h;
   always #5 clk = ~clk;
   aic_host_model host_i (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff));
   aic_cmd_unit #(.CFG_DEFAULT(CFG_D), .CFG_ALT(CFG_A), .DEF_CYLS(16'h0900), .CARD_SECTORS(SECTORS),
      .TICK_CYC(TICK)) aic_cmd_unit_i (.clk(clk), .rst_b(rst_b), .direct_disk_mode(direct_disk_mode),
      .drive_number(drive_number), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .str_wr(str_wr), .str_addr(str_addr),
      .str_data(str_data), .status_ff(status_ff), .intrq_ff(intrq_ff), .idle_mode_ff(idle_mode_ff),
      .auto_pd_en_ff(auto_pd_en_ff), .power_down_ff(power_down_ff),
      .sectors_per_track_ff(sectors_per_track_ff), .max_head_ff(max_head_ff));
   // =====================================
   // helpers
   function automatic logic [16:0] exp_word(input int i, input logic dd);
      if (i >= 10 && i <= 19) return {1'b1, sw[i-10]};
      if (i >= 23 && i <= 44) return {1'b1, sw[i-13]};
      case (i)
         0: return {1'b1, dd ? CFG_A : CFG_D};
         1, 54: return 17'h1_0900;
         3: return 17'h1_0004;
         6: return 17'h1_0020;
         60: return {1'b1, SECTORS[15:0]};
         61: return {1'b1, SECTORS[31:16]};
         7: return {1'b1, SECTORS[31:16]};
         8: return {1'b1, SECTORS[15:0]};
         22: return 17'h1_0004;
         45, 46: return 17'h1_2020;
         47: return 17'h1_0001;
         49, 51: return 17'h1_0200;
         53: return 17'h1_0003;
         55: return 17'h1_0004;
         56: return 17'h1_0020;
         57: return {1'b1, CAP[15:0]};
         58: return {1'b1, CAP[31:16]};
         59: return 17'h1_0100;
         63: return dd ? 17'h1_0407 : 17'h1_0000;
         64: return 17'h1_0003;
         65, 66: return dd ? 17'h1_0050 : 17'h1_0000;
         67, 68: return 17'h1_0050;
         163: return 17'h1_0492;
         164: return 17'h1_001b;
         default: return 17'h1_0000;
      endcase
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: %s got %h want %h", $time, msg, seen, exp);
      end
   endtask
   task automatic cmd(input logic [7:0] c);
      host_i.wr(3'h7, c);
      repeat (3) @(negedge clk);
   endtask
   task automatic ident(input logic dd);
      logic [16:0] e;
      direct_disk_mode = dd;
      repeat (4) @(negedge clk);
      host_i.wr(3'h6, 8'h00);
      cmd(8'hec);
      check({7'h00, intrq_ff, status_ff}, 16'h0148, "identify ready");
      for (int i = 0; i < 256; i++) begin
         while (status_ff[3] !== 1'b1) @(negedge clk);
         host_i.rd(3'h0, v);
         e = exp_word(i, dd);
         if (e[16]) check(v, e[15:0], "identify word");
      end
      repeat (2) @(negedge clk);
      check({8'h00, status_ff}, 16'h0040, "identify end");
      $display("test identify mode %0d done", dd);
   endtask
   task automatic wrap_up;
      $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // a hang costs far more than the ~2k cycles the sequence needs
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         wrap_up();
      end
   end
   // =====================================
   // sequence
   initial begin
      repeat (6) @(negedge clk);
      rst_b = 1'b1;
      repeat (3) @(negedge clk);
      check({status_ff, sectors_per_track_ff}, 16'h4020, "reset status");
      check({9'h000, max_head_ff, intrq_ff, idle_mode_ff, auto_pd_en_ff}, 16'h0018, "reset flags");
      for (int k = 0; k < 32; k++) begin
         @(negedge clk);
         str_wr = 1'b1;
         str_addr = 5'(k);
         str_data = 16'($random(seed));
         sw[k] = str_data;
      end
      @(negedge clk);
      str_wr = 1'b0;
      ident(1'b0);
      ident(1'b1);
      for (int k = 0; k < 2; k++) begin
         n = {5'h00, 3'($random(seed))} + 8'h01;
         host_i.wr(3'h2, n);
         cmd(k ? 8'he3 : 8'h97);
         check({8'h00, status_ff}, 16'h0040, "idle status");
         check({12'h000, intrq_ff, idle_mode_ff, auto_pd_en_ff, power_down_ff}, 16'h000e, "idle timer");
         repeat (n * TICK + 10) @(negedge clk);
         check({15'h0000, power_down_ff}, 16'h0001, "power down");
         host_i.wr(3'h2, 8'h00);
         cmd(k ? 8'he3 : 8'h97);
         repeat (n * TICK + 10) @(negedge clk);
         check({12'h000, intrq_ff, idle_mode_ff, auto_pd_en_ff, power_down_ff}, 16'h000c, "idle no timer");
      end
      $display("test idle done");
      for (int k = 0; k < 2; k++) begin
         host_i.wr(3'h2, 8'($random(seed)) | 8'h01);
         cmd(k ? 8'he1 : 8'h95);
         check({12'h000, intrq_ff, idle_mode_ff, auto_pd_en_ff, power_down_ff}, 16'h000c, "idle now");
         host_i.rd(3'h7, v);
         check({7'h00, intrq_ff, v[7:0]}, 16'h0040, "status read");
      end
      $display("test idle immediate done");
      for (int k = 0; k < 4; k++) begin
         for (int a = 1; a < 6; a++) host_i.wr(3'(a), 8'($random(seed)));
         n = 8'($random(seed));
         h = 8'($random(seed)) & 8'h0f;
         host_i.wr(3'h2, n);
         host_i.wr(3'h6, {4'ha, h[3:0]});
         cmd(8'h91);
         check({sectors_per_track_ff, 4'h0, max_head_ff}, {n, h}, "drive parameters");
      end
      $display("test drive parameters done");
      host_i.wr(3'h6, 8'h10);
      cmd(8'hec);
      check({7'h00, intrq_ff, status_ff}, 16'h0040, "other drive");
      $display("test other drive done");
      wrap_up();
   end
endmodule // aic_cmd_unit_test
`default_nettype wire
